// File: pkg/ctw_pkg.sv
package ctw_pkg;

	// Control word field positions, shared by all timer control registers
	localparam int CTL_TIMER_ON_BIT   = 15;
	localparam int CTL_STOP_IDLE_BIT  = 13;
	localparam int CTL_GATED_BIT      = 6;
	localparam int CTL_PAIR32_BIT     = 3;
	localparam int CTL_SYNC_BIT       = 2;
	localparam int CTL_CLKSEL_BIT     = 1;

	// Reset values
	localparam logic [15:0] CTL_RESET    = 16'h0000;
	localparam logic [15:0] COUNT_RESET  = 16'h0000;
	localparam logic [15:0] PERIOD_RESET = 16'hFFFF;

	// Register selector on the word access port
	typedef enum logic [2:0] {
		CTW_SEL_T1_COUNT  = 3'h0,
		CTW_SEL_T1_PERIOD = 3'h1,
		CTW_SEL_LO_COUNT  = 3'h2,
		CTW_SEL_LO_PERIOD = 3'h3,
		CTW_SEL_HI_COUNT  = 3'h4,
		CTW_SEL_HI_PERIOD = 3'h5,
		CTW_SEL_HOLD      = 3'h6,
		CTW_SEL_NONE      = 3'h7
	} ctw_sel_t;

	// One word access from the processor side
	typedef struct packed {
		logic        rd;
		logic        wr;
		ctw_sel_t    sel;
		logic [15:0] wdata;
	} ctw_acc_t;

	// Power state of the device
	typedef struct packed {
		logic sleep;
		logic idle;
	} ctw_pwr_t;

	// Gated accumulation machine states, one-hot
	typedef enum logic [2:0] {
		CTW_G_OFF  = 3'b001,
		CTW_G_WAIT = 3'b010,
		CTW_G_RUN  = 3'b100
	} ctw_gstate_t;

endpackage : ctw_pkg

// File: design/ctw_tick.sv
`timescale 1ns/1ps
`default_nettype none

// Decides whether one 16-bit time base advances on this clock edge.
// Shared by the first timer and the pair so the gating stays identical.
module ctw_tick (
	// Control
	input  wire logic [15:0] ctl_i,
	input  wire logic        ext_edge_i,
	input  wire logic        gate_lvl_i,
	input  wire logic        async_ok_i,
	// Power state
	input  wire logic        sleep_i,
	input  wire logic        idle_i,
	// Result
	output logic             tick_o
);

	// Source and power gating
	always_comb begin
		tick_o = 1'b0;
		if (!ctl_i[ctw_pkg::CTL_TIMER_ON_BIT]) begin
			// Timer off
			tick_o = 1'b0;
		end else if (idle_i && ctl_i[ctw_pkg::CTL_STOP_IDLE_BIT]) begin
			// Halted while idle
			tick_o = 1'b0;
		end else if (ctl_i[ctw_pkg::CTL_CLKSEL_BIT]) begin
			// External source; in sleep only an unsynchronised first timer runs
			if (sleep_i)
				tick_o = ext_edge_i && async_ok_i && !ctl_i[ctw_pkg::CTL_SYNC_BIT];
			else
				tick_o = ext_edge_i;
		end else if (sleep_i) begin
			// Instruction clock is stopped in sleep
			tick_o = 1'b0;
		end else if (ctl_i[ctw_pkg::CTL_GATED_BIT]) begin
			// Gated accumulation counts while gate high
			tick_o = gate_lvl_i;
		end else begin
			tick_o = 1'b1;
		end
	end

endmodule : ctw_tick

`default_nettype wire

// File: design/ctw_timer.sv
`timescale 1ns/1ps
`default_nettype none

module ctw_timer (
	// Clock and reset
	input  wire logic              core_clk_i,
	input  wire logic              rstn_i,
	// Word access port
	input  wire ctw_pkg::ctw_acc_t acc_i,
	output logic [15:0]            rdata_o,
	// Control words
	input  wire logic [15:0]       t1_timer_control_i,
	input  wire logic [15:0]       lo_timer_control_i,
	input  wire logic [15:0]       hi_timer_control_i,
	// Interrupt enables
	input  wire logic              t1_period_match_irq_enable_i,
	input  wire logic              lo_period_match_irq_enable_i,
	input  wire logic              hi_period_match_irq_enable_i,
	// Flag clears from software
	input  wire logic              t1_flag_clr_i,
	input  wire logic              lo_flag_clr_i,
	input  wire logic              hi_flag_clr_i,
	// External pins, already one clock wide edges or levels
	input  wire logic              t1_ext_edge_i,
	input  wire logic              low_word_clock_pin_i,
	input  wire logic              hi_ext_edge_i,
	input  wire logic              low_power_osc_enable_i,
	// Power state
	input  wire ctw_pkg::ctw_pwr_t pwr_i,
	// Flags and interrupts
	output logic                   t1_period_match_flag_o,
	output logic                   lo_period_match_flag_o,
	output logic                   hi_period_match_flag_o,
	output logic                   wake_o,
	// Time bases for capture/compare
	output logic [15:0]            t1_count_o,
	output logic [15:0]            lo_count_o,
	output logic [15:0]            hi_count_o
);

	// Count, period and holding state
	logic [15:0] t1_cnt_r;           // First timer count
	logic [15:0] t1_per_r;           // First timer period
	logic [15:0] lo_cnt_r;           // Low-word count
	logic [15:0] lo_per_r;           // Low-word period
	logic [15:0] hi_cnt_r;           // High-word count
	logic [15:0] hi_per_r;           // High-word period
	logic [15:0] hold_r;             // High-word holding register
	logic        gate_d_r;           // Gate pin delayed for edge detection
	ctw_pkg::ctw_gstate_t gst_r;     // Gated accumulation tracking
	ctw_pkg::ctw_gstate_t gst_nxt;

	// Decoded modes
	logic        pair;               // Pair mode chosen by low-word control
	logic        pair_gated;         // Pair running gated accumulation
	logic        gate_fall;          // Falling edge of the gate pin
	logic        t1_tick;
	logic        lo_tick;
	logic        hi_tick;
	logic        lo_match;
	logic        hi_match;
	logic        t1_match;
	logic        pair_match;
	logic        lo_wr;
	logic        lo_rd;

	// Match helper used by all three time bases
	function automatic logic is_match(input logic [15:0] cnt, input logic [15:0] per);
		is_match = (cnt == per);
	endfunction : is_match

	// Only the low-word control governs the pair
	assign pair       = lo_timer_control_i[ctw_pkg::CTL_PAIR32_BIT];
	assign pair_gated = pair && lo_timer_control_i[ctw_pkg::CTL_GATED_BIT]
		&& !lo_timer_control_i[ctw_pkg::CTL_CLKSEL_BIT];
	assign gate_fall  = gate_d_r && !low_word_clock_pin_i;
	assign lo_wr      = acc_i.wr && (acc_i.sel == ctw_pkg::CTW_SEL_LO_COUNT);
	assign lo_rd      = acc_i.rd && (acc_i.sel == ctw_pkg::CTW_SEL_LO_COUNT);

	// First timer: the only one allowed to count unsynchronised
	ctw_tick u_t1_tick (
		.ctl_i      (t1_timer_control_i),
		.ext_edge_i (t1_ext_edge_i),
		.gate_lvl_i (low_power_osc_enable_i ? 1'b0 : t1_ext_edge_i),
		.async_ok_i (1'b1),
		.sleep_i    (pwr_i.sleep),
		.idle_i     (pwr_i.idle),
		.tick_o     (t1_tick)
	);

	// Low word, also the pair's clock and gate; no async path for it
	ctw_tick u_lo_tick (
		.ctl_i      (lo_timer_control_i),
		.ext_edge_i (low_word_clock_pin_i && !gate_d_r),
		.gate_lvl_i (low_word_clock_pin_i),
		.async_ok_i (1'b0),
		.sleep_i    (pwr_i.sleep),
		.idle_i     (pwr_i.idle),
		.tick_o     (lo_tick)
	);

	// High word used alone when not paired
	ctw_tick u_hi_tick (
		.ctl_i      (hi_timer_control_i),
		.ext_edge_i (hi_ext_edge_i),
		.gate_lvl_i (1'b0),
		.async_ok_i (1'b0),
		.sleep_i    (pwr_i.sleep),
		.idle_i     (pwr_i.idle),
		.tick_o     (hi_tick)
	);

	assign t1_match   = is_match(t1_cnt_r, t1_per_r);
	assign lo_match   = is_match(lo_cnt_r, lo_per_r);
	assign hi_match   = is_match(hi_cnt_r, hi_per_r);
	assign pair_match = lo_match && hi_match;

	// Gate edge tracker
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			gate_d_r <= 1'b0;
		else
			gate_d_r <= low_word_clock_pin_i;
	end

	// Gated accumulation state: waits for gate high, then runs to the falling edge
	always_comb begin
		gst_nxt = gst_r;
		case (gst_r)
			ctw_pkg::CTW_G_OFF:  if (pair_gated) gst_nxt = ctw_pkg::CTW_G_WAIT;
			ctw_pkg::CTW_G_WAIT: begin
				if (!pair_gated)
					gst_nxt = ctw_pkg::CTW_G_OFF;
				else if (low_word_clock_pin_i)
					gst_nxt = ctw_pkg::CTW_G_RUN;
			end
			ctw_pkg::CTW_G_RUN: begin
				if (!pair_gated)
					gst_nxt = ctw_pkg::CTW_G_OFF;
				else if (gate_fall)
					gst_nxt = ctw_pkg::CTW_G_WAIT;
			end
			default: gst_nxt = ctw_pkg::CTW_G_OFF;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			gst_r <= ctw_pkg::CTW_G_OFF;
		else
			gst_r <= gst_nxt;
	end

	// First timer count; a write wins over counting
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			t1_cnt_r <= ctw_pkg::COUNT_RESET;
		else if (acc_i.wr && acc_i.sel == ctw_pkg::CTW_SEL_T1_COUNT)
			t1_cnt_r <= acc_i.wdata;
		else if (t1_tick)
			t1_cnt_r <= t1_match ? 16'h0000 : t1_cnt_r + 16'h0001;
	end

	// Low-word count: pair rolls over on combined match
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			lo_cnt_r <= ctw_pkg::COUNT_RESET;
		else if (lo_wr)
			lo_cnt_r <= acc_i.wdata;
		else if (lo_tick) begin
			if (pair)
				lo_cnt_r <= pair_match ? 16'h0000 : lo_cnt_r + 16'h0001;
			else
				lo_cnt_r <= lo_match ? 16'h0000 : lo_cnt_r + 16'h0001;
		end
	end

	// High-word count: carry from low word in pair mode
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			hi_cnt_r <= ctw_pkg::COUNT_RESET;
		else if (pair && lo_wr)
			hi_cnt_r <= hold_r;
		else if (!pair && acc_i.wr && acc_i.sel == ctw_pkg::CTW_SEL_HI_COUNT)
			hi_cnt_r <= acc_i.wdata;
		else if (pair) begin
			// High-word controls ignored here
			if (lo_tick && pair_match)
				hi_cnt_r <= 16'h0000;
			else if (lo_tick && lo_cnt_r == 16'hFFFF)
				hi_cnt_r <= hi_cnt_r + 16'h0001;
		end else if (hi_tick)
			hi_cnt_r <= hi_match ? 16'h0000 : hi_cnt_r + 16'h0001;
	end

	// Holding register, active only in pair mode
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			hold_r <= ctw_pkg::COUNT_RESET;
		else if (pair && lo_rd)
			hold_r <= hi_cnt_r;
		else if (pair && acc_i.wr && acc_i.sel == ctw_pkg::CTW_SEL_HOLD)
			hold_r <= acc_i.wdata;
	end

	// Period registers
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			t1_per_r <= ctw_pkg::PERIOD_RESET;
			lo_per_r <= ctw_pkg::PERIOD_RESET;
			hi_per_r <= ctw_pkg::PERIOD_RESET;
		end else if (acc_i.wr) begin
			case (acc_i.sel)
				ctw_pkg::CTW_SEL_T1_PERIOD: t1_per_r <= acc_i.wdata;
				ctw_pkg::CTW_SEL_LO_PERIOD: lo_per_r <= acc_i.wdata;
				ctw_pkg::CTW_SEL_HI_PERIOD: hi_per_r <= acc_i.wdata;
				default: ;
			endcase
		end
	end

	// Read data, registered; pair read sees counts before this edge
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			rdata_o <= 16'h0000;
		else if (acc_i.rd) begin
			case (acc_i.sel)
				ctw_pkg::CTW_SEL_T1_COUNT:  rdata_o <= t1_cnt_r;
				ctw_pkg::CTW_SEL_T1_PERIOD: rdata_o <= t1_per_r;
				ctw_pkg::CTW_SEL_LO_COUNT:  rdata_o <= lo_cnt_r;
				ctw_pkg::CTW_SEL_LO_PERIOD: rdata_o <= lo_per_r;
				ctw_pkg::CTW_SEL_HI_COUNT:  rdata_o <= hi_cnt_r;
				ctw_pkg::CTW_SEL_HI_PERIOD: rdata_o <= hi_per_r;
				ctw_pkg::CTW_SEL_HOLD:      rdata_o <= hold_r;
				default:                    rdata_o <= 16'h0000;
			endcase
		end
	end

	// First timer flag: sets also in sleep when async set beats clear
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			t1_period_match_flag_o <= 1'b0;
		else if (t1_tick && t1_match)
			t1_period_match_flag_o <= 1'b1;
		else if (t1_flag_clr_i)
			t1_period_match_flag_o <= 1'b0;
	end

	// Low-word flag unused while paired
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			lo_period_match_flag_o <= 1'b0;
		else if (!pair && lo_tick && lo_match)
			lo_period_match_flag_o <= 1'b1;
		else if (lo_flag_clr_i)
			lo_period_match_flag_o <= 1'b0;
	end

	// High-word flag: gate fall in gated pair, match otherwise; cleared only by software
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			hi_period_match_flag_o <= 1'b0;
		else if (gst_r == ctw_pkg::CTW_G_RUN && gate_fall)
			hi_period_match_flag_o <= 1'b1;
		else if (pair && !pair_gated && lo_tick && pair_match)
			hi_period_match_flag_o <= 1'b1;                   // Gated pair skips this
		else if (!pair && hi_tick && hi_match)
			hi_period_match_flag_o <= 1'b1;
		else if (hi_flag_clr_i)
			hi_period_match_flag_o <= 1'b0;
	end

	// Wake request from an enabled first-timer match during sleep
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			wake_o <= 1'b0;
		else
			wake_o <= pwr_i.sleep && t1_tick && t1_match && t1_period_match_irq_enable_i;
	end

	// Registered time bases for capture/compare
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			t1_count_o <= 16'h0000;
			lo_count_o <= 16'h0000;
			hi_count_o <= 16'h0000;
		end else begin
			t1_count_o <= t1_cnt_r;
			lo_count_o <= lo_cnt_r;
			hi_count_o <= hi_cnt_r;
		end
	end

endmodule : ctw_timer

`default_nettype wire

// File: tb/ctw_chk_assertions.sv
`timescale 1ns/1ps
`default_nettype none

// Port watcher for the timer; counts reach the ports one cycle late
module ctw_chk (
	// Clock and reset
	input wire logic              core_clk_i,
	input wire logic              rstn_i,
	// Stimulus side
	input wire ctw_pkg::ctw_acc_t acc_i,
	input wire logic [15:0]       t1_timer_control_i,
	input wire logic [15:0]       lo_timer_control_i,
	input wire logic              t1_period_match_irq_enable_i,
	input wire logic              hi_flag_clr_i,
	input wire logic              t1_ext_edge_i,
	input wire logic              low_word_clock_pin_i,
	input wire ctw_pkg::ctw_pwr_t pwr_i,
	// Design outputs
	input wire logic [15:0]       rdata_o,
	input wire logic              t1_period_match_flag_o,
	input wire logic              hi_period_match_flag_o,
	input wire logic              wake_o,
	input wire logic [15:0]       t1_count_o,
	input wire logic [15:0]       lo_count_o,
	input wire logic [15:0]       hi_count_o
);
	// Decoded conditions, kept as nets so the properties stay short
	wire logic pair  = lo_timer_control_i[3];
	wire logic gated = lo_timer_control_i == 16'h804C;
	wire logic rd_lo = acc_i.rd && acc_i.sel == ctw_pkg::CTW_SEL_LO_COUNT;
	wire logic rd_hd = acc_i.rd && acc_i.sel == ctw_pkg::CTW_SEL_HOLD;
	wire logic wr_lo = acc_i.wr && acc_i.sel == ctw_pkg::CTW_SEL_LO_COUNT;
	wire logic wr_hd = acc_i.wr && acc_i.sel == ctw_pkg::CTW_SEL_HOLD;
	wire logic t1_as = t1_timer_control_i[15] && t1_timer_control_i[2:1] == 2'h1;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);

	// Word reads see the value from before the access edge
	property p_lo_read; rd_lo |=> rdata_o == lo_count_o; endproperty
	a_lo_read: assert property (p_lo_read) else $error("low read value");
	property p_hd_read; pair && rd_lo ##1 rd_hd |=> rdata_o == $past(hi_count_o); endproperty
	a_hd_read: assert property (p_hd_read) else $error("holding snapshot");
	// Pair load lands in both words together
	property p_pair_wr;
		pair && wr_hd ##1 wr_lo |-> ##2
			(hi_count_o == $past(acc_i.wdata, 3) && lo_count_o == $past(acc_i.wdata, 2));
	endproperty
	a_pair_wr: assert property (p_pair_wr) else $error("pair load");
	// Sleep freezes the pair even with its pin toggling
	property p_sleep; (pwr_i.sleep && !acc_i.wr)[*3] |-> $stable(lo_count_o) && $stable(hi_count_o); endproperty
	a_sleep: assert property (p_sleep) else $error("pair ran in sleep");
	property p_idle; (pwr_i.idle && lo_timer_control_i[13] && !acc_i.wr)[*3] |-> $stable(lo_count_o); endproperty
	a_idle: assert property (p_idle) else $error("ran in idle");
	// Unsynchronised first timer advances on every pin edge in sleep
	property p_async;
		pwr_i.sleep && t1_as && t1_ext_edge_i && !acc_i.wr |-> ##2 t1_count_o != $past(t1_count_o);
	endproperty
	a_async: assert property (p_async) else $error("first timer stalled");
	property p_fall; gated && $fell(low_word_clock_pin_i) |=> hi_period_match_flag_o; endproperty
	a_fall: assert property (p_fall) else $error("no flag on gate fall");
	// Only the gate fall may raise the flag; matches just roll over
	property p_quiet;
		gated && !$fell(low_word_clock_pin_i) && !hi_period_match_flag_o |=> !hi_period_match_flag_o;
	endproperty
	a_quiet: assert property (p_quiet) else $error("flag without gate fall");
	property p_sticky; hi_period_match_flag_o && !hi_flag_clr_i |=> hi_period_match_flag_o; endproperty
	a_sticky: assert property (p_sticky) else $error("flag dropped");
	property p_wake;
		$rose(t1_period_match_flag_o) && $past(pwr_i.sleep) && t1_period_match_irq_enable_i
			|-> wake_o ##1 !wake_o;
	endproperty
	a_wake: assert property (p_wake) else $error("wake pulse");

	// Main scenarios reached
	c_wake: cover property (wake_o);
	c_fall: cover property (gated && $fell(low_word_clock_pin_i));
	c_pair: cover property (pair && rd_lo ##1 rd_hd);
endmodule : ctw_chk

`default_nettype wire

// File: tb/cascaded_timer_word_access_power_bench.sv
`timescale 1ns/1ps
`default_nettype none

module cascaded_timer_word_access_power_bench;
	logic              core_clk_i, rstn_i, wake_o;
	ctw_pkg::ctw_acc_t acc_i;
	ctw_pkg::ctw_pwr_t pwr_i;
	logic [15:0]       rdata_o, t1_count_o, lo_count_o, hi_count_o;
	logic [15:0]       t1_timer_control_i, lo_timer_control_i, hi_timer_control_i;
	logic              t1_period_match_irq_enable_i, lo_period_match_irq_enable_i;
	logic              hi_period_match_irq_enable_i, t1_flag_clr_i, lo_flag_clr_i;
	logic              hi_flag_clr_i, t1_ext_edge_i, low_word_clock_pin_i, hi_ext_edge_i;
	logic              low_power_osc_enable_i, t1_period_match_flag_o;
	logic              lo_period_match_flag_o, hi_period_match_flag_o;
	int                errors, checked, seed, n, k;
	logic [31:0]       v, want;

	// Block under test
	ctw_timer ctw_timer_inst (.core_clk_i, .rstn_i, .acc_i, .rdata_o, .t1_timer_control_i,
		.lo_timer_control_i, .hi_timer_control_i, .t1_period_match_irq_enable_i,
		.lo_period_match_irq_enable_i, .hi_period_match_irq_enable_i, .t1_flag_clr_i,
		.lo_flag_clr_i, .hi_flag_clr_i, .t1_ext_edge_i, .low_word_clock_pin_i, .hi_ext_edge_i,
		.low_power_osc_enable_i, .pwr_i, .t1_period_match_flag_o, .lo_period_match_flag_o,
		.hi_period_match_flag_o, .wake_o, .t1_count_o, .lo_count_o, .hi_count_o);

	// 50 MHz core clock
	initial begin
		core_clk_i = 1'b0;
		forever #10 core_clk_i = ~core_clk_i;
	end

	// Step past the edge so inputs never race the sampling edge
	task automatic step(input int c);
		repeat (c) @(posedge core_clk_i);
		#2;
	endtask : step
	// Count a comparison and report any mismatch
	task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask : check
	// One access per edge; left driven so back-to-back calls stay legal
	task automatic acc(input logic r, input logic w, input ctw_pkg::ctw_sel_t s,
		input logic [15:0] d);
		acc_i = '{r, w, s, d};
		step(1);
	endtask : acc
	task automatic idle(input int c);
		acc_i = '0;
		step(c);
	endtask : idle
	// Upper half parked first, lower half commits both
	task automatic put32(input logic [31:0] d);
		acc(1'b0, 1'b1, ctw_pkg::CTW_SEL_HOLD, d[31:16]);
		acc(1'b0, 1'b1, ctw_pkg::CTW_SEL_LO_COUNT, d[15:0]);
	endtask : put32
	// Lower half first, so the upper half is snapshotted with it
	task automatic get32(input string what, input logic [31:0] e);
		acc(1'b1, 1'b0, ctw_pkg::CTW_SEL_LO_COUNT, 16'h0000);
		v[15:0] = rdata_o;
		acc(1'b1, 1'b0, ctw_pkg::CTW_SEL_HOLD, 16'h0000);
		v[31:16] = rdata_o;
		check(what, e, v);
	endtask : get32
	// Expected counter after t ticks with rollover on match
	function automatic logic [31:0] adv(input logic [31:0] c, input logic [31:0] p, input int t);
		for (int j = 0; j < t; j++)
			c = (c == p) ? 32'h0000_0000 : c + 32'h0000_0001;
		return c;
	endfunction : adv
	task automatic complete_run;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run

	// Hang guard
	initial begin
		#1000000;
		errors++;
		complete_run();
	end

	// Main sequence
	initial begin
		seed = 32'h9E40;
		errors = 0;
		checked = 0;
		rstn_i = 1'b0;
		acc_i = '0;
		pwr_i = '0;
		{t1_timer_control_i, lo_timer_control_i, hi_timer_control_i} = '0;
		{t1_period_match_irq_enable_i, lo_period_match_irq_enable_i} = '0;
		{hi_period_match_irq_enable_i, t1_flag_clr_i, lo_flag_clr_i, hi_flag_clr_i} = '0;
		{t1_ext_edge_i, low_word_clock_pin_i, hi_ext_edge_i, low_power_osc_enable_i} = '0;
		step(12);
		rstn_i = 1'b1;
		// Coherent pair load and readback, all-ones first
		lo_timer_control_i = 16'h0008;
		for (k = 0; k < 4; k++) begin
			v = (k == 0) ? 32'hFFFF_FFFF : $random(seed);
			want = v;
			put32(v);
			get32("pair readback", want);
		end
		// Holding path inert outside pair mode
		lo_timer_control_i = 16'h0000;
		acc(1'b0, 1'b1, ctw_pkg::CTW_SEL_HI_COUNT, 16'h1234);
		put32(32'hABCD_0005);
		idle(2);
		check("unpaired high", 32'h0000_1234, {16'h0000, hi_count_o});
		acc(1'b1, 1'b0, ctw_pkg::CTW_SEL_HOLD, 16'h0000);
		check("unpaired holding", {16'h0000, want[31:16]}, {16'h0000, rdata_o});
		// Unpaired low word owns its flag: count 5 meets period 7 on the third tick
		acc(1'b0, 1'b1, ctw_pkg::CTW_SEL_LO_PERIOD, 16'h0007);
		lo_timer_control_i = 16'h8000;
		idle(2);
		check("low flag early", 32'h0, {31'h0, lo_period_match_flag_o});
		idle(1);
		check("low flag on match", 32'h1, {31'h0, lo_period_match_flag_o});
		lo_flag_clr_i = 1'b1;
		idle(1);
		lo_flag_clr_i = 1'b0;
		check("low flag cleared", 32'h0, {31'h0, lo_period_match_flag_o});
		// Gated pair: carry into upper word, then combined rollover
		for (k = 0; k < 2; k++) begin
			want = k ? 32'h0001_0003 : 32'hFFFF_FFFF;
			v = k ? 32'h0001_0002 : 32'h0000_FFFD;
			n = k ? 3 : 3 + ($random(seed) & 7);
			acc(1'b0, 1'b1, ctw_pkg::CTW_SEL_LO_PERIOD, want[15:0]);
			acc(1'b0, 1'b1, ctw_pkg::CTW_SEL_HI_PERIOD, want[31:16]);
			lo_timer_control_i = 16'h0008;
			put32(v);
			lo_timer_control_i = 16'h804C;
			hi_timer_control_i = 16'h8000;
			low_word_clock_pin_i = 1'b1;
			idle(n);
			check("flag before fall", 32'h0, {31'h0, hi_period_match_flag_o});
			low_word_clock_pin_i = 1'b0;
			step(1);
			check("flag on fall", 32'h1, {31'h0, hi_period_match_flag_o});
			step(3);
			check("flag held", 32'h1, {31'h0, hi_period_match_flag_o});
			check("low flag paired", 32'h0, {31'h0, lo_period_match_flag_o});
			get32("gated count", adv(v, want, n));
			hi_flag_clr_i = 1'b1;
			idle(1);
			hi_flag_clr_i = 1'b0;
			check("flag cleared", 32'h0, {31'h0, hi_period_match_flag_o});
		end
		hi_timer_control_i = 16'h0000;
		// Idle with stop-in-idle set, then clear
		acc(1'b0, 1'b1, ctw_pkg::CTW_SEL_LO_PERIOD, 16'hFFFF);
		pwr_i.idle = 1'b1;
		for (k = 0; k < 2; k++) begin
			lo_timer_control_i = k ? 16'h8000 : 16'hA000;
			idle(2);
			want = {16'h0000, lo_count_o};
			step(4);
			check("idle count", k ? adv(want, 32'hFFFF, 4) : want, {16'h0000, lo_count_o});
		end
		pwr_i.idle = 1'b0;
		// One-second crystal setup; sleep only once the count shows the crystal runs
		acc(1'b0, 1'b1, ctw_pkg::CTW_SEL_T1_COUNT, 16'h0000);
		acc(1'b0, 1'b1, ctw_pkg::CTW_SEL_T1_PERIOD, 16'h7FFF);
		t1_timer_control_i = 16'h8002;
		for (k = 0; k < 16 && t1_count_o == 16'h0000; k++) begin
			t1_ext_edge_i = k[0];
			step(1);
		end
		t1_ext_edge_i = 1'b0;
		check("crystal running", 32'h1, {31'h0, t1_count_o != 16'h0000});
		// A dead crystal would never wake us, so give up here
		if (t1_count_o == 16'h0000)
			complete_run();
		// Sleep: only the unsynchronised first timer keeps running
		acc(1'b0, 1'b1, ctw_pkg::CTW_SEL_T1_PERIOD, 16'h0003);
		acc(1'b0, 1'b1, ctw_pkg::CTW_SEL_T1_COUNT, 16'h0000);
		t1_timer_control_i = 16'h8002;
		lo_timer_control_i = 16'h8002;
		t1_period_match_irq_enable_i = 1'b1;
		pwr_i.sleep = 1'b1;
		idle(2);
		want = {16'h0000, lo_count_o};
		n = 0;
		for (k = 0; k < 8; k++) begin
			t1_ext_edge_i = ~k[0];
			low_word_clock_pin_i = ~k[0];
			step(1);
			n += wake_o;
		end
		check("wake pulses", 32'h1, n);
		check("sleep flag", 32'h1, {31'h0, t1_period_match_flag_o});
		check("sleep t1 count", 32'h0, {16'h0000, t1_count_o});
		check("sleep low count", want, {16'h0000, lo_count_o});
		// Synchronised first timer must also stop in sleep
		t1_flag_clr_i = 1'b1;
		t1_timer_control_i = 16'h8006;
		step(1);
		t1_flag_clr_i = 1'b0;
		t1_ext_edge_i = 1'b1;
		step(2);
		t1_ext_edge_i = 1'b0;
		step(2);
		check("synced sleep", 32'h0, {16'h0000, t1_count_o});
		pwr_i.sleep = 1'b0;
		complete_run();
	end
endmodule : cascaded_timer_word_access_power_bench

bind ctw_timer ctw_chk ctw_chk_inst (.core_clk_i, .rstn_i, .acc_i, .t1_timer_control_i,
	.lo_timer_control_i, .t1_period_match_irq_enable_i, .hi_flag_clr_i, .t1_ext_edge_i,
	.low_word_clock_pin_i, .pwr_i, .rdata_o, .t1_period_match_flag_o, .hi_period_match_flag_o,
	.wake_o, .t1_count_o, .lo_count_o, .hi_count_o);

`default_nettype wire
